// *** verilog/dacc_pkg.sv ***
// Package for the dual converter control block: types, codes, timing counts.
// Assumes a single 40 MHz system clock.
package dacc_pkg;
    localparam int SYS_CLK_MHZ = 40;
    localparam int SAMPLE_CYCLES = 1;
    localparam int CONVERT_CYCLES = 5;
    localparam int TOTAL_CYCLES = SAMPLE_CYCLES + CONVERT_CYCLES;
    localparam int RESULT_W = 10;
    localparam int CHSEL_W = 3;
    localparam int PRESCALE_CODE_W = 3;
    localparam int PRESCALE_W = 6;
    localparam int QUEUE_DEPTH = 2;
    localparam logic [CHSEL_W-1:0] CHSEL_RESET = 3'h0;
    localparam logic [PRESCALE_CODE_W-1:0] PRESCALE_RESET = 3'h0;

    // Shadowed control bits
    typedef struct packed {
        logic unit1_enable;
        logic unit2_enable;
        logic continuous_run_select;
        logic int_enable;
        logic [CHSEL_W-1:0] unit1_input_select;
        logic [CHSEL_W-1:0] unit2_input_select;
    } dacc_ctrl_t;

    localparam dacc_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, CHSEL_RESET, CHSEL_RESET};

    typedef enum logic [1:0] {
        TRIG_SOFTWARE,
        TRIG_PIN,
        TRIG_EVENT
    } dacc_trig_t;

    function automatic logic [PRESCALE_W-1:0] prescale_value(
        input logic [PRESCALE_CODE_W-1:0] code);
        case (code)
            3'h0: prescale_value = 6'h04;
            3'h1: prescale_value = 6'h06;
            3'h2: prescale_value = 6'h08;
            3'h3: prescale_value = 6'h0a;
            3'h4: prescale_value = 6'h0c;
            3'h5: prescale_value = 6'h10;
            3'h6: prescale_value = 6'h14;
            default: prescale_value = 6'h20;
        endcase
    endfunction
endpackage

// *** verilog/dacc_result_queue.sv ***
// Two-entry result queue for one converter unit, overwrite-oldest on overrun.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module dacc_result_queue
    import dacc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_push,
    input wire logic [RESULT_W-1:0] i_data,
    input wire logic i_pop,
    output logic [RESULT_W-1:0] o_head,
    output logic [1:0] o_count
);
    logic [RESULT_W-1:0] entry_reg [QUEUE_DEPTH];
    logic [1:0] count_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            entry_reg[0] <= '0;
            entry_reg[1] <= '0;
            count_reg <= 2'h0;
        end else begin
            if (i_push && i_pop && count_reg != 2'h0) begin
                if (count_reg == 2'h2) begin
                    entry_reg[0] <= entry_reg[1];
                    entry_reg[1] <= i_data;
                end else begin
                    entry_reg[0] <= i_data;
                end
            end else if (i_push) begin
                if (count_reg == 2'h2) begin
                    // Oldest result dropped
                    entry_reg[0] <= entry_reg[1];
                    entry_reg[1] <= i_data;
                end else begin
                    entry_reg[count_reg[0]] <= i_data;
                    count_reg <= count_reg + 2'h1;
                end
            end else if (i_pop && count_reg != 2'h0) begin
                // Oldest first
                entry_reg[0] <= entry_reg[1];
                count_reg <= count_reg - 2'h1;
            end
        end
    end

    assign o_head = entry_reg[0];
    assign o_count = count_reg;
endmodule

// *** verilog/dacc_top.sv ***
// Dual converter conversion control: triggers, shadowing, prescaler, sequencing.
// Assumes analog front ends return 10-bit codes; pins pass two-stage synchronisers.
// Summary of operation
// - Two converter units sample and convert one channel each simultaneously.
// - Each unit selects its input through its own eight-to-one multiplexer.
// - Channels 0-7 feed unit one, channels 8-15 feed unit two.
// - Single and continuous conversion modes are supported.
// - Start by software, external pin edge, or timer/capture events.
// - Shadowed control bits load into active copy while idle and when a conversion completes.
// - End of conversion sets flag; interrupt request when enabled.
// - Each unit keeps a two-entry result queue.
// - A third unfetched result discards the oldest.
// - One prescaled cycle sampling, five converting, six in total.
// - Prescaler code selects divide by 4,6,8,10,12,16,20 or 32.
// - Results are 10-bit unsigned codes from 0 to 1023.
// - Inputs 0,1,8,9 become digital I/O when pin configuration says so.
// - Writing one clears the done flag; zero has no effect.
// - Active status reads one during conversion, zero after.
// - Writing one to immediate trigger starts conversion; zero does nothing.
// - Three-bit shadowed field selects unit two input, 000 to 111.
`timescale 1ns/1ps
module dacc_top
    import dacc_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic i_ctrl_write,
    input wire dacc_ctrl_t i_ctrl_data,
    input wire logic [PRESCALE_CODE_W-1:0] i_prescale_code,
    input wire logic i_immediate_convert_trigger,
    input wire logic i_flag_clear_write,
    input wire logic i_flag_clear_data,
    input wire logic i_ext_start_pin,
    input wire logic i_event_start,
    input wire logic i_capture4_start,
    input wire logic [RESULT_W-1:0] i_unit1_sample,
    input wire logic [RESULT_W-1:0] i_unit2_sample,
    input wire logic i_unit1_queue_read,
    input wire logic i_unit2_queue_read,
    input wire logic [3:0] i_digital_io_select,
    output logic o_sample_hold,
    output logic o_convert_strobe,
    output logic [2:0] o_unit1_mux,
    output logic [2:0] o_unit2_mux,
    output logic [3:0] o_analog_disable,
    output logic o_conversion_active,
    output logic o_conv_done_flag,
    output logic o_int_request,
    output dacc_ctrl_t o_active_ctrl,
    output logic [RESULT_W-1:0] o_unit1_result_queue,
    output logic [RESULT_W-1:0] o_unit2_result_queue,
    output logic [1:0] o_unit1_count,
    output logic [1:0] o_unit2_count
);
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_DONE} dacc_state_t;

    dacc_state_t state_reg;
    dacc_ctrl_t shadow_reg, active_reg;
    logic [PRESCALE_W-1:0] presc_cnt_reg;
    logic [2:0] phase_cnt_reg;
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;
    logic start_pending_reg;
    logic flag_reg, irq_reg, active_out_reg, sh_reg, conv_reg;
    logic [2:0] mux1_reg, mux2_reg;
    logic [3:0] dio_reg;
    logic [RESULT_W-1:0] head1, head2;
    logic [1:0] cnt1, cnt2;
    logic adc_tick, start_req, finish, push1, push2;

    // Pin synchroniser and edge detect
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= i_ext_start_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // Start sources combined
    assign start_req = i_immediate_convert_trigger || (pin_sync_reg && !pin_prev_reg)
        || i_event_start || i_capture4_start;

    // Prescaler
    assign adc_tick = (presc_cnt_reg == prescale_value(i_prescale_code) - 6'h01);
    // Restart on completion so a continuous round samples a full period
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            presc_cnt_reg <= 6'h00;
        end else if (adc_tick || finish || presc_cnt_reg >= prescale_value(i_prescale_code)) begin
            presc_cnt_reg <= 6'h00;
        end else begin
            presc_cnt_reg <= presc_cnt_reg + 6'h01;
        end
    end

    // Start held until an idle prescaler tick with no new start
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            start_pending_reg <= 1'b0;
        end else if (start_req) begin
            start_pending_reg <= 1'b1;
        end else if (state_reg == ST_IDLE && adc_tick) begin
            start_pending_reg <= 1'b0;
        end
    end

    // Sequencer: one sample cycle then five convert cycles
    assign finish = (state_reg == ST_DONE);
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg <= ST_IDLE;
            phase_cnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (adc_tick && (start_pending_reg || start_req)) begin
                        state_reg <= ST_SAMPLE;
                        phase_cnt_reg <= 3'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (adc_tick) begin
                        state_reg <= ST_CONVERT;
                        phase_cnt_reg <= 3'(SAMPLE_CYCLES);
                    end
                end
                ST_CONVERT: begin
                    if (adc_tick) begin
                        if (phase_cnt_reg == 3'(TOTAL_CYCLES - 1)) begin
                            state_reg <= ST_DONE;
                        end else begin
                            phase_cnt_reg <= phase_cnt_reg + 3'h1;
                        end
                    end
                end
                ST_DONE: begin
                    // Continuous mode restarts at once
                    if (shadow_reg.continuous_run_select) begin
                        state_reg <= ST_SAMPLE;
                        phase_cnt_reg <= 3'h0;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Shadow and active control copies
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            shadow_reg <= CTRL_RESET;
            active_reg <= CTRL_RESET;
        end else begin
            if (i_ctrl_write) begin
                shadow_reg <= i_ctrl_data;
            end
            if (finish || (state_reg == ST_IDLE)) begin
                active_reg <= i_ctrl_write ? i_ctrl_data : shadow_reg;
            end
        end
    end

    // Done flag, set wins over clear
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            if (finish) begin
                flag_reg <= 1'b1;
            end else if (i_flag_clear_write && i_flag_clear_data) begin
                flag_reg <= 1'b0;
            end
            irq_reg <= (finish || flag_reg && !(i_flag_clear_write && i_flag_clear_data))
                && active_reg.int_enable;
        end
    end

    // Pin-facing outputs and status
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            active_out_reg <= 1'b0;
            sh_reg <= 1'b0;
            conv_reg <= 1'b0;
            mux1_reg <= CHSEL_RESET;
            mux2_reg <= CHSEL_RESET;
            dio_reg <= 4'h0;
        end else begin
            active_out_reg <= (state_reg == ST_SAMPLE) || (state_reg == ST_CONVERT);
            sh_reg <= (state_reg == ST_SAMPLE);
            conv_reg <= (state_reg == ST_CONVERT);
            mux1_reg <= active_reg.unit1_input_select;
            mux2_reg <= active_reg.unit2_input_select;
            dio_reg <= i_digital_io_select;
        end
    end

    // Disabled units leave their queue unchanged
    assign push1 = finish && active_reg.unit1_enable;
    assign push2 = finish && active_reg.unit2_enable;

    dacc_result_queue u_queue1 (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_push(push1),
        .i_data(i_unit1_sample),
        .i_pop(i_unit1_queue_read),
        .o_head(head1),
        .o_count(cnt1)
    );

    dacc_result_queue u_queue2 (
        .i_clk(I_SYS_CLK),
        .i_rst_b(I_RST_B),
        .i_push(push2),
        .i_data(i_unit2_sample),
        .i_pop(i_unit2_queue_read),
        .o_head(head2),
        .o_count(cnt2)
    );

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            o_unit1_result_queue <= '0;
            o_unit2_result_queue <= '0;
            o_unit1_count <= 2'h0;
            o_unit2_count <= 2'h0;
            o_active_ctrl <= CTRL_RESET;
        end else begin
            o_unit1_result_queue <= head1;
            o_unit2_result_queue <= head2;
            o_unit1_count <= cnt1;
            o_unit2_count <= cnt2;
            o_active_ctrl <= active_reg;
        end
    end

    assign o_sample_hold = sh_reg;
    assign o_convert_strobe = conv_reg;
    assign o_unit1_mux = mux1_reg;
    assign o_unit2_mux = mux2_reg;
    assign o_analog_disable = dio_reg;
    assign o_conversion_active = active_out_reg;
    assign o_conv_done_flag = flag_reg;
    assign o_int_request = irq_reg;
endmodule

// *** dv/dacc_afe_model.sv ***
// Front end stand-in: returns a code built from a bench level and the live mux select.
// Assumes the bench holds the level steady while a conversion runs.
`timescale 1ns/1ps
module dacc_afe_model (
    input wire logic [6:0] i_level,
    input wire logic [2:0] i_unit1_mux,
    input wire logic [2:0] i_unit2_mux,
    output logic [9:0] o_unit1_sample,
    output logic [9:0] o_unit2_sample
);
    // Unit two sees the upper inputs, so its level is inverted
    assign o_unit1_sample = {i_level, i_unit1_mux};
    assign o_unit2_sample = {~i_level, i_unit2_mux};
endmodule

// *** dv/dacc_top_chk.sv ***
// Port-level checker for the dual converter control block.
// Assumes one clock and the asynchronous active-low reset of the top module.
`timescale 1ns/1ps
module dacc_top_chk
    import dacc_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic [PRESCALE_CODE_W-1:0] i_prescale_code,
    input wire logic i_flag_clear_write,
    input wire logic i_flag_clear_data,
    input wire logic [3:0] i_digital_io_select,
    input wire logic o_sample_hold,
    input wire logic o_convert_strobe,
    input wire logic [2:0] o_unit1_mux,
    input wire logic [2:0] o_unit2_mux,
    input wire logic [3:0] o_analog_disable,
    input wire logic o_conversion_active,
    input wire logic o_conv_done_flag,
    input wire logic o_int_request,
    input wire dacc_ctrl_t o_active_ctrl,
    input wire logic [1:0] o_unit1_count,
    input wire logic [1:0] o_unit2_count
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    localparam int PS [8] = '{4, 6, 8, 10, 12, 16, 20, 32};
    int hold_cnt;
    int conv_cnt;
    // Length of the current sample and convert phases
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            hold_cnt <= 0;
            conv_cnt <= 0;
        end else begin
            hold_cnt <= o_sample_hold ? hold_cnt + 1 : 0;
            conv_cnt <= o_convert_strobe ? conv_cnt + 1 : 0;
        end
    end
    a_sample_len: assert property (
        $fell(o_sample_hold) |-> hold_cnt == PS[i_prescale_code])
        else $error("sample phase length wrong");
    a_convert_len: assert property (
        $fell(o_convert_strobe) |-> conv_cnt == 5 * PS[i_prescale_code])
        else $error("convert phase length wrong");
    a_sample_to_conv: assert property (
        $fell(o_sample_hold) |-> o_convert_strobe)
        else $error("convert does not follow sample");
    a_phase_active: assert property (
        (o_sample_hold || o_convert_strobe) |-> o_conversion_active)
        else $error("active status low in a phase");
    a_mux_held: assert property (
        o_conversion_active && $past(o_conversion_active)
        |-> $stable(o_unit1_mux) && $stable(o_unit2_mux))
        else $error("input select changed mid conversion");
    a_irq_follows: assert property (
        o_conv_done_flag && o_active_ctrl.int_enable |-> ##[0:1] o_int_request)
        else $error("interrupt request missing");
    a_irq_no_flag: assert property (
        !o_conv_done_flag && $past(!o_conv_done_flag) |-> !o_int_request)
        else $error("interrupt request without flag");
    a_zero_write: assert property (
        i_flag_clear_write && !i_flag_clear_data && o_conv_done_flag |=> o_conv_done_flag)
        else $error("zero write cleared flag");
    a_count_bound: assert property (
        o_unit1_count != 2'h3 && o_unit2_count != 2'h3)
        else $error("queue count above two");
    a_dio_copy: assert property (
        o_analog_disable == $past(i_digital_io_select))
        else $error("digital select not copied");
endmodule
bind dacc_top dacc_top_chk i_dacc_top_chk (.I_SYS_CLK, .I_RST_B, .i_prescale_code,
    .i_flag_clear_write, .i_flag_clear_data, .i_digital_io_select, .o_sample_hold,
    .o_convert_strobe, .o_unit1_mux, .o_unit2_mux, .o_analog_disable, .o_conversion_active,
    .o_conv_done_flag, .o_int_request, .o_active_ctrl, .o_unit1_count, .o_unit2_count);

// *** dv/dacc_top_tb_top.sv ***
// Self-checking bench for the dual converter control block with a queue model.
// Assumes the front end stand-in and the bound checker are compiled alongside.
`timescale 1ns/1ps
module dacc_top_tb_top;
    import dacc_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, imm = 0, fcw = 0, fcd = 0, pin = 0, evs = 0, cap = 0;
    logic rd1 = 0, rd2 = 0, hold, strobe, active, flag, irq;
    logic [2:0] ps = 3'h0, mux1, mux2;
    logic [3:0] dio = 4'h0, adis;
    logic [6:0] lvl = 7'h0;
    logic [9:0] s1, s2, h1, h2;
    logic [1:0] c1, c2;
    dacc_ctrl_t ctl = '0, act, actl;
    int miscompares = 0, total_checks = 0, n;
    int q1[$], q2[$];
    int psv [8] = '{4, 6, 8, 10, 12, 16, 20, 32};
    dacc_top i_dacc_top (.I_SYS_CLK(clk), .I_RST_B(rst_b), .i_ctrl_write(wr), .i_ctrl_data(ctl),
        .i_prescale_code(ps), .i_immediate_convert_trigger(imm), .i_flag_clear_write(fcw),
        .i_flag_clear_data(fcd), .i_ext_start_pin(pin), .i_event_start(evs),
        .i_capture4_start(cap), .i_unit1_sample(s1), .i_unit2_sample(s2),
        .i_unit1_queue_read(rd1), .i_unit2_queue_read(rd2), .i_digital_io_select(dio),
        .o_sample_hold(hold), .o_convert_strobe(strobe), .o_unit1_mux(mux1), .o_unit2_mux(mux2),
        .o_analog_disable(adis), .o_conversion_active(active), .o_conv_done_flag(flag),
        .o_int_request(irq), .o_active_ctrl(actl), .o_unit1_result_queue(h1),
        .o_unit2_result_queue(h2), .o_unit1_count(c1), .o_unit2_count(c2));
    dacc_afe_model i_dacc_afe_model (.i_level(lvl), .i_unit1_mux(mux1), .i_unit2_mux(mux2),
        .o_unit1_sample(s1), .o_unit2_sample(s2));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic setctl(input dacc_ctrl_t c);
        ctl = c;
        wr = 1;
        tick(1);
        wr = 0;
    endtask
    task automatic start(input int src);
        lvl = 7'($urandom);
        case (src)
            0: imm = 1;
            1: evs = 1;
            2: cap = 1;
            default: pin = 1;
        endcase
        tick(src == 3 ? 3 : 1);
        {imm, evs, cap, pin} = 4'h0;
    endtask
    task automatic waitdone();
        n = 0;
        while (flag !== 1'b1) begin
            tick(1);
            n++;
            if (n > 1000) begin
                miscompares++;
                complete_run();
            end
        end
    endtask
    task automatic clr();
        tick(1);
        check("irq", irq, act.int_enable);
        fcw = 1;
        tick(1);
        check("flag kept", flag, 1'b1);
        fcd = 1;
        tick(1);
        {fcw, fcd} = 2'h0;
        tick(1);
        check("flag cleared", flag, 1'b0);
    endtask
    task automatic conv(input int src);
        act = ctl;
        start(src);
        waitdone();
        check("latency", n > 6 * psv[ps] && n < 7 * psv[ps] + 3, 1'b1);
        if (act.unit1_enable) q1.push_back({lvl, act.unit1_input_select});
        if (act.unit2_enable) q2.push_back({~lvl, act.unit2_input_select});
        if (q1.size() > 2) void'(q1.pop_front());
        if (q2.size() > 2) void'(q2.pop_front());
        check("idle", active, 1'b0);
        clr();
    endtask
    task automatic drain();
        check("count1", c1, q1.size());
        check("count2", c2, q2.size());
        while (q1.size() > 0 || q2.size() > 0) begin
            if (q1.size() > 0) check("head1", h1, q1.pop_front());
            if (q2.size() > 0) check("head2", h2, q2.pop_front());
            {rd1, rd2} = 2'h3;
            tick(1);
            {rd1, rd2} = 2'h0;
            tick(2);
        end
        check("counts empty", {c1, c2}, 4'h0);
    endtask
    initial begin
        void'($urandom(32'hef36));
        tick(5);
        rst_b = 1;
        tick(1);
        check("reset flag", {flag, irq, active, c1, c2, actl}, 0);
        dio = 4'($urandom);
        tick(2);
        check("dio", adis, dio);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            ps = 3'(i);
            // Unit one always on, unit two on codes 2,3,6,7, single mode
            setctl({1'b1, 1'(i >> 1), 1'b0, 1'($urandom), 6'($urandom)});
            conv(i % 4);
            drain();
        end
        $display("test prescale and sources done");
        ps = 3'h0;
        for (int i = 0; i < 3; i++) conv(i);
        drain();
        {rd1, rd2} = 2'h3;
        tick(1);
        {rd1, rd2} = 2'h0;
        tick(2);
        check("pop empty", {c1, c2}, 4'h0);
        $display("test overrun done");
        setctl({4'hd, 3'h2, 3'h5});
        act = ctl;
        start(0);
        tick(3);
        setctl({4'h9, 3'h6, 3'h1});
        check("shadow held", actl, act);
        waitdone();
        q1.push_back({lvl, 3'h2});
        q2.push_back({~lvl, 3'h5});
        tick(1);
        check("active ctrl", actl, ctl);
        clr();
        conv(1);
        drain();
        $display("test shadow done");
        ps = 3'h7; // Slowest code, the maximum conversion time
        setctl({4'hf, 3'h3, 3'h7});
        act = ctl;
        start(0);
        waitdone();
        clr();
        waitdone();
        check("restart gap", n > 6 * psv[ps] - 5 && n < 6 * psv[ps], 1'b1);
        clr();
        setctl({4'hd, 3'h3, 3'h7});
        n = 0;
        while (active !== 1'b0) begin
            tick(1);
            n++;
            if (n > 1000) begin
                miscompares++;
                complete_run();
            end
        end
        tick(3);
        check("run count", c1, 2'h2);
        for (int k = 0; k < 3 && c1 != 2'h0; k++) begin
            check("run head", h1, {lvl, 3'h3});
            rd1 = 1;
            tick(1);
            rd1 = 0;
            tick(2);
        end
        check("run stopped", active, 1'b0);
        $display("test continuous done");
        complete_run();
    end
endmodule
